// [design/cre_core.sv]
// Purpose: programmer state and effective address unit behind Wishbone
// Assumes: classic Wishbone slave, single clock clk, async reset nrst
// Notes:   one access at a time, ack one cycle after the request
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`include "cre_map.svh"

// Function
// - width strap low selects 8-bit data bus, else 16-bit.
// - in 8-bit mode upper strobe carries A0, lower is the strobe.
// - user and supervisor modes; privileged writes refused in user mode.
// - eight data, eight address registers, 32-bit PC and condition codes.
// - data registers take byte, word, long; address only word, long.
// - any of the sixteen registers may serve as index.
// - supervisor adds own stack pointer and full status word.
// - operands may be bit, decimal digit, byte, word or long.
// - fourteen addressing modes in six families.
// - register direct uses the register itself, no memory access.
// - absolute short from one extension word, long from two.
// - PC relative adds 16-bit offset, or index plus 8-bit offset.
// - postincrement uses then bumps; predecrement drops then uses.
// - indirect with 16-bit offset, or index plus 8-bit offset.
// - auto step is 1 byte, 2 word, 4 long.
// - byte step on stack pointer is two.
// - immediate from extension words; quick from instruction field.
// - implied mode reaches status word, both stack pointers, PC.
module cre_core (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        bus_width_select,
  input  wire logic        mem_strobe,
  input  wire logic        mem_a0,
  input  wire logic        mem_word,
  output logic             upper_strobe_or_addr_bit0,
  output logic             lower_strobe_or_single_strobe,
  output logic             supervisor_mode
);

  cre_pkg::cre_st_t r;
  cre_pkg::cre_st_t n;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // address register view with banked A7
  function automatic logic [31:0] areg(input cre_pkg::cre_st_t s,
                                       input logic [2:0] k);
    if (k != 3'h7) begin
      areg = s.a[k];
    end else begin
      areg = s.sr[`CRE_SR_S] ? s.supervisor_stack_ptr : s.user_stack_ptr;
    end
  endfunction

  function automatic logic [31:0] gpr(input cre_pkg::cre_st_t s,
                                      input logic [3:0] k);
    gpr = k[3] ? areg(s, k[2:0]) : s.d[k[2:0]];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] v,
                                        input logic [3:0]  b);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = b[i] ? v[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // word load into an address register sign extends, long load as is
  function automatic logic [31:0] a_load(input logic [31:0] v,
                                         input logic [3:0]  b);
    a_load = b[3] ? v : {{16{v[15]}}, v[15:0]};
  endfunction

  function automatic logic [31:0] rd_word(input cre_pkg::cre_st_t s,
                                          input logic [7:0] ad,
                                          input logic b8);
    if (ad[7:6] == `CRE_GPR_BASE) begin
      rd_word = gpr(s, ad[5:2]);
    end else begin
      case ({ad[7:2], 2'b00})
        `CRE_OFF_EXT:  rd_word = s.ext;
        `CRE_OFF_EA:   rd_word = s.ea;
        `CRE_OFF_OPND: rd_word = s.opnd;
        `CRE_OFF_SR:   rd_word = {16'h0, s.sr};
        `CRE_OFF_PC:   rd_word = s.pc;
        `CRE_OFF_STAT: rd_word = {29'h0, b8, s.mem, s.refused};
        `CRE_OFF_USP:  rd_word = s.user_stack_ptr;
        `CRE_OFF_SSP:  rd_word = s.supervisor_stack_ptr;
        default:       rd_word = 32'h0;
      endcase
    end
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic       take;
  logic       wr;
  logic [7:0] wadr;
  logic       priv;
  logic       b8;

  assign take = (r.st == cre_pkg::WB_IDLE) && wb_cyc_i && wb_stb_i;
  assign wr   = take && wb_we_i;
  assign wadr = {wb_adr_i[7:2], 2'b00};
  assign priv = r.sr[`CRE_SR_S];

  // ****************************************************************
  // address unit
  // ****************************************************************
  logic [31:0] e_ea;
  logic [31:0] e_opnd;
  logic [31:0] e_an;
  logic        e_anwr;
  logic        e_mem;
  logic        e_bad;
  logic [2:0]  c_reg;

  assign c_reg = wb_dat_i[`CRE_CMD_REG];

  cre_ea u_ea (
    .mode     (wb_dat_i[`CRE_CMD_MODE]),
    .size     (wb_dat_i[`CRE_CMD_SIZE]),
    .regnum   (c_reg),
    .dreg     (r.d[c_reg]),
    .base     (areg(r, c_reg)),
    .idx      (gpr(r, wb_dat_i[`CRE_CMD_IDX])),
    .idx_long (wb_dat_i[`CRE_CMD_IDXL]),
    .pc       (r.pc),
    .ext      (r.ext),
    .sr       (r.sr),
    .user_stack_ptr      (r.user_stack_ptr),
    .supervisor_stack_ptr      (r.supervisor_stack_ptr),
    .ea       (e_ea),
    .opnd     (e_opnd),
    .an_new   (e_an),
    .an_wr    (e_anwr),
    .mem_ref  (e_mem),
    .bad      (e_bad)
  );

  cre_pins u_pins (
    .clk                           (clk),
    .nrst                          (nrst),
    .bus_width_select              (bus_width_select),
    .mem_strobe                    (mem_strobe),
    .mem_a0                        (mem_a0),
    .mem_word                      (mem_word),
    .bus8                          (b8),
    .upper_strobe_or_addr_bit0     (upper_strobe_or_addr_bit0),
    .lower_strobe_or_single_strobe (lower_strobe_or_single_strobe)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n     = r;
    n.ack = 1'b0;
    case (r.st)
      cre_pkg::WB_IDLE: begin
        if (take) begin
          n.st  = cre_pkg::WB_ACK;
          n.ack = 1'b1;
          if (!wb_we_i) begin
            n.rdat = rd_word(r, wb_adr_i, b8);
            if (wadr == `CRE_OFF_STAT) begin
              n.refused = 1'b0;
            end
          end
        end
      end
      cre_pkg::WB_ACK: n.st = cre_pkg::WB_IDLE;
      default:         n.st = cre_pkg::WB_IDLE;
    endcase
    if (wr && wb_adr_i[7:6] == `CRE_GPR_BASE) begin
      if (!wb_adr_i[5]) begin
        n.d[wb_adr_i[4:2]] = merge(r.d[wb_adr_i[4:2]], wb_dat_i,
                                   wb_sel_i);
      end else if (wb_sel_i == 4'hf || wb_sel_i == 4'h3) begin
        // word write sign extends into the address register
        if (wb_adr_i[4:2] != 3'h7) begin
          n.a[wb_adr_i[4:2]] = a_load(wb_dat_i, wb_sel_i);
        end else if (priv) begin
          n.supervisor_stack_ptr = a_load(wb_dat_i, wb_sel_i);
        end else begin
          n.user_stack_ptr = a_load(wb_dat_i, wb_sel_i);
        end
      end else begin
        n.refused = 1'b1;
      end
    end else if (wr) begin
      case (wadr)
        `CRE_OFF_CMD: begin
          n.ea   = e_ea;
          n.opnd = e_opnd;
          n.mem  = e_mem;
          if (e_bad) begin
            n.refused = 1'b1;
          end else if (e_anwr) begin
            if (c_reg != 3'h7) begin
              n.a[c_reg] = e_an;
            end else if (priv) begin
              n.supervisor_stack_ptr = e_an;
            end else begin
              n.user_stack_ptr = e_an;
            end
          end
        end
        `CRE_OFF_EXT: n.ext = merge(r.ext, wb_dat_i, wb_sel_i);
        `CRE_OFF_PC:  n.pc  = merge(r.pc, wb_dat_i, wb_sel_i);
        `CRE_OFF_SR: begin
          if (priv) begin
            n.sr = 16'(merge({16'h0, r.sr}, wb_dat_i, wb_sel_i)
                       & {16'h0, `CRE_SR_MASK});
          end else begin
            // user mode reaches only the condition code byte
            n.sr[7:0] = (wb_sel_i[0] ? wb_dat_i[7:0] : r.sr[7:0])
                        & 8'(`CRE_CCR_MASK);
            if (wb_sel_i[1]) begin
              n.refused = 1'b1;
            end
          end
        end
        `CRE_OFF_USP,
        `CRE_OFF_SSP: begin
          if (!priv) begin
            n.refused = 1'b1;
          end else if (wadr == `CRE_OFF_USP) begin
            n.user_stack_ptr = merge(r.user_stack_ptr, wb_dat_i, wb_sel_i);
          end else begin
            n.supervisor_stack_ptr = merge(r.supervisor_stack_ptr, wb_dat_i, wb_sel_i);
          end
        end
        default: n.mem = r.mem;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r    <= '0;
      r.sr <= `CRE_SR_RST;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o        = r.rdat;
  assign wb_ack_o        = r.ack;
  assign supervisor_mode = r.sr[`CRE_SR_S];

  // ****************************************************************
  // checks
  // ****************************************************************
  logic wr_cmd;
  assign wr_cmd = wr && wadr == `CRE_OFF_CMD;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_delay_a: assert property (take |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  sr_guard_a: assert property (wr && wadr == `CRE_OFF_SR && !priv
      |=> r.sr[15:8] == $past(r.sr[15:8]))
    else $error("user write changed supervisor byte");

  post_long_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_POST
      && c_reg == 3'h2 && wb_dat_i[`CRE_CMD_SIZE] == cre_pkg::SZ_LONG
      |=> r.a[2] == $past(r.a[2]) + 32'h4 && r.ea == $past(r.a[2]))
    else $error("postincrement long wrong");

  pre_sp_a: assert property (wr_cmd && priv
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_PRE
      && c_reg == 3'h7 && wb_dat_i[`CRE_CMD_SIZE] == cre_pkg::SZ_BYTE
      |=> r.supervisor_stack_ptr == $past(r.supervisor_stack_ptr) - 32'h2 && r.ea == r.supervisor_stack_ptr)
    else $error("stack byte predecrement not two");

  abs_short_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_ABSW
      |=> r.ea == {{16{$past(r.ext[15])}}, $past(r.ext[15:0])} && r.mem)
    else $error("absolute short address wrong");

  pc_disp_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_PCD
      |=> r.ea == $past(r.pc) + {{16{$past(r.ext[15])}}, $past(r.ext[15:0])})
    else $error("pc relative address wrong");

  dir_nomem_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_DREG
      |=> !r.mem ##1 !wb_ack_o)
    else $error("register direct flagged memory access");

  abyte_ref_a: assert property (wr && wb_adr_i[7:5] == 3'h3
      && wb_sel_i == 4'h1 |=> r.refused && r.a == $past(r.a))
    else $error("byte write to address register accepted");

  sr_bits_a: assert property ((r.sr & ~`CRE_SR_MASK) == 16'h0)
    else $error("status word holds an unused bit");

  quick_data_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_QUICK && c_reg == 3'h0
      |=> r.opnd == 32'h8 && !r.mem)
    else $error("quick zero field not eight");

  impl_sr_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_IMPL && c_reg[1:0] == 2'h0
      |=> r.opnd == {16'h0, $past(r.sr)})
    else $error("implied status word read wrong");

  usp_guard_a: assert property (wr && wadr == `CRE_OFF_USP
      && !priv |=> r.refused && r.user_stack_ptr == $past(r.user_stack_ptr))
    else $error("user write reached the user stack");

  strobe_eight_a: assert property (b8
      |=> upper_strobe_or_addr_bit0 == $past(mem_a0)
      && lower_strobe_or_single_strobe == $past(mem_strobe))
    else $error("byte bus strobe steering wrong");

  width_sync_a: assert property ($changed(b8)
      |-> b8 == !bus_width_select)
    else $error("bus width follows no strap level");

  abs_long_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_ABSL
      |=> r.ea == $past(r.ext) && r.mem)
    else $error("absolute long address wrong");

  areg_byte_a: assert property (wr_cmd
      && wb_dat_i[`CRE_CMD_MODE] == cre_pkg::M_AREG
      && wb_dat_i[`CRE_CMD_SIZE] == cre_pkg::SZ_BYTE
      |=> r.refused && !r.mem)
    else $error("byte operand on address register accepted");

endmodule

// [design/cre_map.svh]
// Purpose: offsets, field positions, reset values of the core register block
// Assumes: byte addresses on an 8-bit word-aligned bus address
// Notes:   definitions only
`ifndef CRE_MAP_SVH
`define CRE_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CRE_OFF_CMD   8'h00
`define CRE_OFF_EXT   8'h04
`define CRE_OFF_EA    8'h08
`define CRE_OFF_OPND  8'h0c
`define CRE_OFF_SR    8'h10
`define CRE_OFF_PC    8'h14
`define CRE_OFF_STAT  8'h18
`define CRE_OFF_USP   8'h1c
`define CRE_OFF_SSP   8'h20
`define CRE_GPR_BASE  2'h1

// ****************************************************************
// field positions
// ****************************************************************
`define CRE_CMD_MODE  3:0
`define CRE_CMD_REG   6:4
`define CRE_CMD_SIZE  10:8
`define CRE_CMD_IDX   15:12
`define CRE_CMD_IDXL  16
`define CRE_SR_T      15
`define CRE_SR_S      13
`define CRE_SR_IMASK  10:8
`define CRE_SR_X      4
`define CRE_SR_N      3
`define CRE_SR_Z      2
`define CRE_SR_V      1
`define CRE_SR_C      0

// ****************************************************************
// reset values and masks
// ****************************************************************
`define CRE_SR_RST    16'h2700
`define CRE_SR_MASK   16'ha71f
`define CRE_CCR_MASK  16'h001f

`endif

// [design/cre_pkg.sv]
// Purpose: types shared by the core register block
// Assumes: nothing
// Notes:   offsets live in cre_map.svh
package cre_pkg;

  typedef enum logic [3:0] {
    M_DREG  = 4'h0, M_AREG  = 4'h1, M_IND   = 4'h2, M_POST  = 4'h3,
    M_PRE   = 4'h4, M_D16   = 4'h5, M_IDX   = 4'h6, M_ABSW  = 4'h7,
    M_ABSL  = 4'h8, M_PCD   = 4'h9, M_PCX   = 4'ha, M_IMM   = 4'hb,
    M_QUICK = 4'hc, M_IMPL  = 4'hd
  } cre_mode_t;

  typedef enum logic [2:0] {
    SZ_BIT  = 3'h0, SZ_BCD  = 3'h1, SZ_BYTE = 3'h2, SZ_WORD = 3'h3,
    SZ_LONG = 3'h4
  } cre_size_t;

  typedef enum logic [0:0] {
    WB_IDLE = 1'b0, WB_ACK = 1'b1
  } cre_wb_t;

  typedef struct packed {
    logic [7:0][31:0] d;
    logic [6:0][31:0] a;
    logic [31:0]      user_stack_ptr;
    logic [31:0]      supervisor_stack_ptr;
    logic [31:0]      pc;
    logic [31:0]      ext;
    logic [31:0]      ea;
    logic [31:0]      opnd;
    logic [31:0]      rdat;
    logic [15:0]      sr;
    logic             mem;
    logic             refused;
    logic             ack;
    cre_wb_t          st;
  } cre_st_t;

endpackage

// [design/cre_ea.sv]
// Purpose: effective address and operand forming for one command
// Assumes: all inputs from the same clock, purely combinational
// Notes:   caller writes back an_new when an_wr is high
module cre_ea (
  input  wire logic [3:0]  mode,
  input  wire logic [2:0]  size,
  input  wire logic [2:0]  regnum,
  input  wire logic [31:0] dreg,
  input  wire logic [31:0] base,
  input  wire logic [31:0] idx,
  input  wire logic        idx_long,
  input  wire logic [31:0] pc,
  input  wire logic [31:0] ext,
  input  wire logic [15:0] sr,
  input  wire logic [31:0] user_stack_ptr,
  input  wire logic [31:0] supervisor_stack_ptr,
  output logic      [31:0] ea,
  output logic      [31:0] opnd,
  output logic      [31:0] an_new,
  output logic             an_wr,
  output logic             mem_ref,
  output logic             bad
);

  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] sx8(input logic [7:0] v);
    sx8 = {{24{v[7]}}, v};
  endfunction

  // operand width per data type
  function automatic logic [31:0] fit(input logic [2:0] s,
                                      input logic [31:0] v);
    case (cre_pkg::cre_size_t'(s))
      cre_pkg::SZ_BIT:  fit = {31'h0, v[0]};
      cre_pkg::SZ_BCD:  fit = {28'h0, v[3:0]};
      cre_pkg::SZ_BYTE: fit = {24'h0, v[7:0]};
      cre_pkg::SZ_WORD: fit = {16'h0, v[15:0]};
      default:          fit = v;
    endcase
  endfunction

  // auto step, byte on stack pointer kept word aligned
  function automatic logic [31:0] step(input logic [2:0] s,
                                       input logic [2:0] r);
    case (cre_pkg::cre_size_t'(s))
      cre_pkg::SZ_WORD: step = 32'h2;
      cre_pkg::SZ_LONG: step = 32'h4;
      default:          step = (r == 3'h7) ? 32'h2 : 32'h1;
    endcase
  endfunction

  logic [31:0] xv;

  always_comb begin
    xv      = idx_long ? idx : sx16(idx[15:0]);
    ea      = 32'h0;
    opnd    = 32'h0;
    an_new  = base;
    an_wr   = 1'b0;
    mem_ref = 1'b1;
    bad     = 1'b0;
    case (cre_pkg::cre_mode_t'(mode))
      cre_pkg::M_DREG: begin
        opnd    = fit(size, dreg);
        mem_ref = 1'b0;
      end
      cre_pkg::M_AREG: begin
        opnd    = fit(size, base);
        mem_ref = 1'b0;
        bad     = (size < 3'(cre_pkg::SZ_WORD));
      end
      cre_pkg::M_IND:  ea = base;
      cre_pkg::M_POST: begin
        ea     = base;
        an_new = base + step(size, regnum);
        an_wr  = 1'b1;
      end
      cre_pkg::M_PRE: begin
        an_new = base - step(size, regnum);
        ea     = an_new;
        an_wr  = 1'b1;
      end
      cre_pkg::M_D16:  ea = base + sx16(ext[15:0]);
      cre_pkg::M_IDX:  ea = base + xv + sx8(ext[7:0]);
      cre_pkg::M_ABSW: ea = sx16(ext[15:0]);
      cre_pkg::M_ABSL: ea = ext;
      cre_pkg::M_PCD:  ea = pc + sx16(ext[15:0]);
      cre_pkg::M_PCX:  ea = pc + xv + sx8(ext[7:0]);
      cre_pkg::M_IMM: begin
        opnd    = fit(size, ext);
        mem_ref = 1'b0;
      end
      cre_pkg::M_QUICK: begin
        opnd    = (regnum == 3'h0) ? 32'h8 : {29'h0, regnum};
        mem_ref = 1'b0;
      end
      cre_pkg::M_IMPL: begin
        mem_ref = 1'b0;
        case (regnum[1:0])
          2'h0:    opnd = {16'h0, sr};
          2'h1:    opnd = user_stack_ptr;
          2'h2:    opnd = supervisor_stack_ptr;
          default: opnd = pc;
        endcase
      end
      default: begin
        bad     = 1'b1;
        mem_ref = 1'b0;
      end
    endcase
  end

endmodule

// [design/cre_pins.sv]
// Purpose: bus width strap and data strobe pin steering
// Assumes: width strap is asynchronous and held static
// Notes:   strobes are active high here
module cre_pins (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic bus_width_select,
  input  wire logic mem_strobe,
  input  wire logic mem_a0,
  input  wire logic mem_word,
  output logic      bus8,
  output logic      upper_strobe_or_addr_bit0,
  output logic      lower_strobe_or_single_strobe
);

  typedef struct packed {
    logic [2:0] sy;
    logic       wide;
    logic       us;
    logic       ls;
  } cre_pin_t;

  cre_pin_t r;
  cre_pin_t n;

  always_comb begin
    n    = r;
    n.sy = {r.sy[1:0], bus_width_select};
    // change counts once 2nd and 3rd stage agree
    if (r.sy[1] == r.sy[2]) begin
      n.wide = r.sy[2];
    end
    if (!r.wide) begin
      n.us = mem_a0;
      n.ls = mem_strobe;
    end else begin
      n.us = mem_strobe & (mem_word | ~mem_a0);
      n.ls = mem_strobe & (mem_word | mem_a0);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{sy: 3'h7, wide: 1'b1, us: 1'b0, ls: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign bus8                          = ~r.wide;
  assign upper_strobe_or_addr_bit0     = r.us;
  assign lower_strobe_or_single_strobe = r.ls;

endmodule

// [dv/cre_mem_model.sv]
// Purpose: external memory lane decode seen from the strobe pins
// Assumes: strobes active high, width strap held static
// Notes:   reports which byte lanes the memory would enable
module cre_mem_model (
  input  wire logic       bus_width_select,
  input  wire logic       upper_strobe_or_addr_bit0,
  input  wire logic       lower_strobe_or_single_strobe,
  output logic      [1:0] lane_en
);
  // ********
  // lane decode
  // ********
  always_comb begin
    if (!bus_width_select) begin
      // one byte lane, address bit picks odd or even byte
      lane_en = {lower_strobe_or_single_strobe & ~upper_strobe_or_addr_bit0,
                 lower_strobe_or_single_strobe & upper_strobe_or_addr_bit0};
    end else begin
      lane_en = {upper_strobe_or_addr_bit0, lower_strobe_or_single_strobe};
    end
  end
endmodule

// [dv/tb.sv]
// Purpose: self-checking bench of the core register block
// Assumes: ack one cycle after request, strap held static while running
// Notes:   reads note expected data in a queue, a watcher compares
`include "cre_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, cyc, stb, we, bws, ms, ma0, mw;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] di, wb_dat_o, w_exp, a2, x, e, p, u;
  logic        wb_ack_o, ups, los, sup;
  logic [1:0]  lane;
  logic [31:0] q[$];
  logic [3:0]  ml[7];
  int          error_cnt, n_compared, cyc_n;

  cre_core dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_width_select(bws),
    .mem_strobe(ms), .mem_a0(ma0), .mem_word(mw),
    .upper_strobe_or_addr_bit0(ups),
    .lower_strobe_or_single_strobe(los), .supervisor_mode(sup));
  cre_mem_model mem_u (.bus_width_select(bws),
    .upper_strobe_or_addr_bit0(ups),
    .lower_strobe_or_single_strobe(los), .lane_en(lane));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ********
  // helpers
  // ********
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [1:0] g, input logic [1:0] t);
    n_compared++;
    if (g !== t) fail("pin or mode level");
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    di  <= d;
    sel <= s;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] t);
    q.push_back(t);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic cmd(input logic [3:0] m, input logic [2:0] r,
                     input logic [2:0] s, input logic [3:0] i);
    wr(`CRE_OFF_CMD, {15'h0, 1'b1, i, 1'b0, s, 1'b0, r, m});
  endtask
  task automatic pins();
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      {ms, ma0, mw} <= 3'($urandom());
      @(posedge clk);
      @(negedge clk);
      chk(lane, {ms & (mw & bws | !ma0), ms & (mw & bws | ma0)});
    end
  endtask
  function automatic logic [31:0] ea_exp(input logic [3:0] m);
    logic [31:0] d8;
    logic [31:0] d16;
    d8  = {{24{e[7]}}, e[7:0]};
    d16 = {{16{e[15]}}, e[15:0]};
    case (m)
      cre_pkg::M_D16:  return a2 + d16;
      cre_pkg::M_IDX:  return a2 + x + d8;
      cre_pkg::M_ABSW: return d16;
      cre_pkg::M_ABSL: return e;
      cre_pkg::M_PCD:  return p + d16;
      cre_pkg::M_PCX:  return p + x + d8;
      default:         return a2;
    endcase
  endfunction

  // ********
  // read watcher and timeout
  // ********
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      n_compared++;
      if (q.size() == 0) begin
        fail("read without expectation");
      end else begin
        w_exp = q.pop_front();
        if (wb_dat_o !== w_exp) fail("read data");
      end
    end
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    {cyc, stb, we, ms, ma0, mw} = 6'h00;
    {adr, sel, di} = 44'h0;
    bws = 1'b1;
    nrst = 1'b0;
    ml = '{cre_pkg::M_IND, cre_pkg::M_D16, cre_pkg::M_IDX, cre_pkg::M_ABSW,
           cre_pkg::M_ABSL, cre_pkg::M_PCD, cre_pkg::M_PCX};
    void'($urandom(32'h0203));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(`CRE_OFF_SR, 32'h2700);
    rd(`CRE_OFF_STAT, 32'h0);
    chk({1'b0, sup}, 2'h1);
    $display("test reset done");
    x = $urandom();
    wr(8'h4c, x);
    rd(8'h4c, x);
    bus(1'b1, 8'h60, 32'h0001_8000, 4'h3);
    rd(8'h60, 32'hffff_8000);
    bus(1'b1, 8'h60, 32'h55, 4'h1);
    rd(8'h60, 32'hffff_8000);
    rd(`CRE_OFF_STAT, 32'h1);
    rd(`CRE_OFF_STAT, 32'h0);
    $display("test registers done");
    a2 = $urandom() & 32'hffff_fff0;
    p = $urandom() & 32'hffff_fffe;
    e = {16'($urandom()), 16'h7f80};
    wr(8'h68, a2);
    wr(`CRE_OFF_EXT, e);
    wr(`CRE_OFF_PC, p);
    for (int k = 0; k < 7; k++) begin
      cmd(ml[k], 3'h2, cre_pkg::SZ_LONG, 4'h3);
      rd(`CRE_OFF_EA, ea_exp(ml[k]));
    end
    rd(`CRE_OFF_STAT, 32'h2);
    cmd(cre_pkg::M_IDX, 3'h2, cre_pkg::SZ_LONG, 4'ha);
    rd(`CRE_OFF_EA, a2 + a2 + 32'hffff_ff80);
    for (int s = 2; s < 5; s++) begin
      cmd(cre_pkg::M_POST, 3'h2, 3'(s), 4'h3);
      rd(`CRE_OFF_EA, a2);
      a2 = a2 + (32'h1 << (s - 2));
      rd(8'h68, a2);
      cmd(cre_pkg::M_PRE, 3'h2, 3'(s), 4'h3);
      a2 = a2 - (32'h1 << (s - 2));
      rd(`CRE_OFF_EA, a2);
    end
    wr(8'h7c, p);
    cmd(cre_pkg::M_PRE, 3'h7, cre_pkg::SZ_BYTE, 4'h3);
    rd(`CRE_OFF_SSP, p - 32'h2);
    $display("test address modes done");
    cmd(cre_pkg::M_DREG, 3'h3, cre_pkg::SZ_BYTE, 4'h3);
    rd(`CRE_OFF_OPND, {24'h0, x[7:0]});
    rd(`CRE_OFF_STAT, 32'h0);
    cmd(cre_pkg::M_AREG, 3'h2, cre_pkg::SZ_BYTE, 4'h3);
    rd(`CRE_OFF_STAT, 32'h1);
    cmd(cre_pkg::M_IMM, 3'h0, cre_pkg::SZ_WORD, 4'h3);
    rd(`CRE_OFF_OPND, {16'h0, e[15:0]});
    cmd(cre_pkg::M_QUICK, 3'h0, cre_pkg::SZ_LONG, 4'h3);
    rd(`CRE_OFF_OPND, 32'h8);
    cmd(4'he, 3'h0, cre_pkg::SZ_LONG, 4'h3);
    rd(`CRE_OFF_STAT, 32'h1);
    u = $urandom();
    wr(`CRE_OFF_USP, u);
    for (int r = 0; r < 4; r++) begin
      cmd(cre_pkg::M_IMPL, 3'(r), cre_pkg::SZ_LONG, 4'h3);
      rd(`CRE_OFF_OPND, r == 0 ? 32'h2700 : r == 1 ? u :
         r == 2 ? p - 32'h2 : p);
    end
    $display("test operands done");
    wr(`CRE_OFF_SR, 32'h0);
    @(negedge clk);
    chk({1'b0, sup}, 2'h0);
    wr(`CRE_OFF_USP, 32'h0);
    rd(`CRE_OFF_STAT, 32'h1);
    rd(8'h7c, u);
    bus(1'b1, `CRE_OFF_SR, 32'h27f5, 4'h1);
    rd(`CRE_OFF_SR, 32'h15);
    rd(`CRE_OFF_STAT, 32'h0);
    bus(1'b1, `CRE_OFF_SR, 32'h2700, 4'h3);
    rd(`CRE_OFF_STAT, 32'h1);
    $display("test user mode done");
    pins();
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    bws <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`CRE_OFF_STAT, 32'h4);
    pins();
    $display("test pins done");
    summarize();
  end
endmodule
